// >>> common/spsf_defs.vh
`ifndef SPSF_DEFS_VH
`define SPSF_DEFS_VH

// ==================================================================
// register offsets
`define SPSF_OFS_MODE 8'h00
`define SPSF_OFS_CTRL 8'h02
`define SPSF_OFS_TXH 8'h03
`define SPSF_OFS_STAT 8'h04
`define SPSF_OFS_RXH 8'h05

// ==================================================================
// status register bit positions
`define SPSF_B_TXEMPTY 7
`define SPSF_B_RXFULL 6
`define SPSF_B_OVERRUN 5
`define SPSF_B_FRAMING 4
`define SPSF_B_PARITY 3
`define SPSF_B_TXDONE 2
`define SPSF_B_RXMP 1
`define SPSF_B_TXMP 0

// ==================================================================
// control and mode register bit positions
`define SPSF_B_TXON 5
`define SPSF_B_PEN 5
`define SPSF_B_ODD 4

// ==================================================================
// reset values
`define SPSF_RST_STAT 8'h84
`define SPSF_RST_CTRL 8'h00
`define SPSF_RST_MODE 8'h00
`define SPSF_RST_TXH 8'hFF
`define SPSF_RST_RXH 8'h00

// ==================================================================
// transmit fifo shape
`define SPSF_FIFO_WIDTH 8
`define SPSF_FIFO_DEPTH 16
`define SPSF_FIFO_AW 4

`endif

// >>> dv/spsf_station.sv
`timescale 1ns/1ps
module spsf_station #(
  parameter BIT_TIME = 40
) (
  input wire clk,
  input wire rst_b,
  input wire tx_load,
  input wire [7:0] tx_shift_data,
  input wire tx_multiproc_out,
  output logic tx_shift_ready,
  output logic tx_last_bit,
  output logic rx_frame_done = 1'b0,
  output logic [7:0] rx_shift_data = 8'h00,
  output logic rx_parity_bit = 1'b0,
  output logic rx_stop_bit = 1'b0,
  output logic rx_multiproc_in = 1'b0
);
  logic [8:0] got[$];
  int cnt;
  // ==========================================================
  // shifter: busy for a whole character after each load
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_shift_ready <= 1'b1;
      tx_last_bit <= 1'b0;
      cnt <= 0;
    end else if (tx_load) begin
      got.push_back({tx_multiproc_out, tx_shift_data});
      tx_shift_ready <= 1'b0;
      cnt <= BIT_TIME;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      tx_last_bit <= 1'b1;
    end else begin
      tx_last_bit <= 1'b0;
      tx_shift_ready <= 1'b1;
    end
  end
  // ==========================================================
  // receive side: frame contents inverted once the pulse is over
  task automatic send_frame(input logic [7:0] v, input logic p, s, m);
    @(posedge clk);
    rx_shift_data <= v;
    rx_parity_bit <= p;
    rx_stop_bit <= s;
    rx_multiproc_in <= m;
    rx_frame_done <= 1'b1;
    @(posedge clk);
    rx_frame_done <= 1'b0;
    rx_shift_data <= ~v;
    rx_parity_bit <= ~p;
    rx_stop_bit <= ~s;
    rx_multiproc_in <= ~m;
  endtask
endmodule // spsf_station

// >>> dv/spsf_status_asserts.sv
`timescale 1ns/1ps
module spsf_status_asserts (
  input wire clk,
  input wire rst_b,
  input wire standby,
  input wire tx_shift_ready,
  input wire tx_last_bit,
  input wire tx_load,
  input wire tx_multiproc_out,
  input wire transmitter_on,
  input wire rx_frame_done,
  input wire rx_stop_bit,
  input wire dma_rx_rd,
  input wire [7:0] status_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // flag behaviour
  property p_rst; $rose(rst_b) |-> status_out == 8'h84; endproperty
  a_rst: assert property (p_rst)
    else $error("flags wrong after reset");
  property p_load;
    tx_load |-> $past(transmitter_on && tx_shift_ready && !standby);
  endproperty
  a_load: assert property (p_load)
    else $error("load without enable or free shifter");
  property p_mpb; tx_load |-> tx_multiproc_out == status_out[0]; endproperty
  a_mpb: assert property (p_mpb)
    else $error("sent multiproc bit differs");
  property p_full;
    rx_frame_done && !status_out[6] && !standby
      |=> status_out[6] || status_out[4] || status_out[3];
  endproperty
  a_full: assert property (p_full)
    else $error("frame left no full or error flag");
  property p_orun;
    rx_frame_done && status_out[6] && !standby && !dma_rx_rd
      |=> status_out[6:5] == 2'h3;
  endproperty
  a_orun: assert property (p_orun)
    else $error("overrun not flagged");
  property p_fer;
    rx_frame_done && !status_out[6] && !rx_stop_bit && !standby
      |=> status_out[4] && !status_out[6];
  endproperty
  a_fer: assert property (p_fer)
    else $error("bad stop bit not flagged");
  property p_stby; standby |=> status_out[7:2] == 6'h21; endproperty
  a_stby: assert property (p_stby)
    else $error("standby pattern wrong");
  property p_dma; dma_rx_rd && !rx_frame_done |=> !status_out[6]; endproperty
  a_dma: assert property (p_dma)
    else $error("dma read kept rx full");
  property p_tx_complete;
    tx_last_bit && status_out[7] && !standby |=> status_out[2];
  endproperty
  a_tx_complete: assert property (p_tx_complete)
    else $error("tx complete not set");
  c_load: cover property (tx_load);
  c_orun: cover property (rx_frame_done && status_out[6]);
  c_stby: cover property (standby);
endmodule // spsf_status_asserts

bind spsf_status spsf_status_asserts u_asserts (
  .clk(clk),
  .rst_b(rst_b),
  .standby(standby),
  .tx_shift_ready(tx_shift_ready),
  .tx_last_bit(tx_last_bit),
  .tx_load(tx_load),
  .tx_multiproc_out(tx_multiproc_out),
  .transmitter_on(transmitter_on),
  .rx_frame_done(rx_frame_done),
  .rx_stop_bit(rx_stop_bit),
  .dma_rx_rd(dma_rx_rd),
  .status_out(status_out)
);

// >>> dv/tb_top.sv
`timescale 1ns/1ps
`include "spsf_defs.vh"
module tb_top;
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, standby = 1'b0;
  logic dma_tx_valid = 1'b0, dma_rx_rd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, dma_tx_data = 8'h00, d;
  wire tx_shift_ready, tx_last_bit, tx_load, tx_multiproc_out;
  wire transmitter_on, rx_frame_done, rx_parity_bit, rx_stop_bit;
  wire rx_multiproc_in, dma_tx_ready;
  wire [7:0] rdata, tx_shift_data, rx_shift_data, dma_rx_data, status_out;
  int errors = 0, comparisons = 0;
  localparam logic [7:0] ST = `SPSF_OFS_STAT;
  always #5 clk = ~clk;
  spsf_status DUT (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .standby(standby),
    .tx_shift_ready(tx_shift_ready), .tx_last_bit(tx_last_bit),
    .tx_load(tx_load), .tx_shift_data(tx_shift_data),
    .tx_multiproc_out(tx_multiproc_out), .transmitter_on(transmitter_on),
    .rx_frame_done(rx_frame_done), .rx_shift_data(rx_shift_data),
    .rx_parity_bit(rx_parity_bit), .rx_stop_bit(rx_stop_bit),
    .rx_multiproc_in(rx_multiproc_in), .dma_tx_valid(dma_tx_valid),
    .dma_tx_data(dma_tx_data), .dma_tx_ready(dma_tx_ready),
    .dma_rx_rd(dma_rx_rd), .dma_rx_data(dma_rx_data),
    .status_out(status_out));
  spsf_station #(.BIT_TIME(40)) st (.clk(clk), .rst_b(rst_b),
    .tx_load(tx_load), .tx_shift_data(tx_shift_data),
    .tx_multiproc_out(tx_multiproc_out), .tx_shift_ready(tx_shift_ready),
    .tx_last_bit(tx_last_bit), .rx_frame_done(rx_frame_done),
    .rx_shift_data(rx_shift_data), .rx_parity_bit(rx_parity_bit),
    .rx_stop_bit(rx_stop_bit), .rx_multiproc_in(rx_multiproc_in));
  // ==========================================================
  // bus and compare helpers
  task automatic check(input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wr_reg(input logic [7:0] a, v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic wait_sent(input int k);
    for (int i = 0; i < 3000 && st.got.size() < k; i++) @(posedge clk);
    repeat (44) @(posedge clk);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    wr_reg(ST, 8'h00);
    rd_reg(ST);
    check(d, `SPSF_RST_STAT);
    rd_reg(8'h07);
    check(d, 8'h00);
    wr_reg(ST, 8'hFF);
    rd_reg(ST);
    check(d, 8'h85);
    $display("reset test done");
  endtask
  task automatic t_sw_tx;
    wr_reg(`SPSF_OFS_TXH, 8'h3C);
    wr_reg(`SPSF_OFS_CTRL, 8'h20);
    rd_reg(ST);
    check({7'h00, transmitter_on}, 8'h01);
    wr_reg(ST, 8'h7B);
    rd_reg(ST);
    check(d, 8'h81);
    check(st.got[0][7:0], 8'h3C);
    check({7'h00, st.got[0][8]}, 8'h01);
    rd_reg(ST);
    wr_reg(ST, 8'h7B);
    wr_reg(`SPSF_OFS_CTRL, 8'h00);
    rd_reg(ST);
    check(d, 8'h85);
    check({7'h00, transmitter_on}, 8'h00);
    wait_sent(2);
    check(8'(st.got.size()), 8'h01);
    $display("software transmit test done");
  endtask
  task automatic t_dma_tx;
    int n, k;
    n = 0;
    k = 0;
    wr_reg(`SPSF_OFS_CTRL, 8'h20);
    wr_reg(ST, 8'hF8);
    @(posedge clk);
    dma_tx_valid <= 1'b1;
    dma_tx_data <= 8'h10;
    while (k < 3) begin
      @(posedge clk);
      if (dma_tx_ready === 1'b1) begin
        n++;
        k = 0;
        dma_tx_data <= 8'h10 + 8'(n);
      end else k++;
    end
    dma_tx_valid <= 1'b0;
    check({7'h00, n >= 16}, 8'h01);
    rd_reg(ST);
    check(d & 8'h04, 8'h00);
    wait_sent(n + 1);
    rd_reg(ST);
    check(d & 8'hFC, 8'h84);
    for (int j = 0; j < n; j++)
      check(st.got[j + 1][7:0], 8'h10 + 8'(j));
    check({7'h00, st.got[1][8]}, 8'h00);
    $display("dma transmit test done");
  endtask
  task automatic t_rx;
    st.send_frame(8'hA5, 1'b0, 1'b1, 1'b1);
    rd_reg(ST);
    check(d, 8'hC6);
    check(status_out, 8'hC6);
    st.send_frame(8'h3C, 1'b0, 1'b1, 1'b0);
    rd_reg(ST);
    check(d, 8'hE4);
    check(dma_rx_data, 8'hA5);
    wr_reg(ST, 8'h9F);
    rd_reg(ST);
    check(d, 8'h85);
    st.send_frame(8'h11, 1'b0, 1'b0, 1'b0);
    rd_reg(ST);
    check(d, 8'h95);
    wr_reg(ST, 8'hEF);
    wr_reg(`SPSF_OFS_MODE, 8'h20);
    st.send_frame(8'h01, 1'b0, 1'b1, 1'b0);
    rd_reg(ST);
    check(d, 8'h8D);
    wr_reg(ST, 8'hF7);
    wr_reg(`SPSF_OFS_MODE, 8'h30);
    st.send_frame(8'h01, 1'b0, 1'b1, 1'b0);
    rd_reg(ST);
    check(d, 8'hC5);
    @(posedge clk);
    dma_rx_rd <= 1'b1;
    @(posedge clk);
    dma_rx_rd <= 1'b0;
    rd_reg(ST);
    check(d, 8'h85);
    $display("receive test done");
  endtask
  task automatic t_standby;
    st.send_frame(8'h5A, 1'b0, 1'b0, 1'b1);
    @(posedge clk);
    standby <= 1'b1;
    repeat (2) @(posedge clk);
    standby <= 1'b0;
    rd_reg(ST);
    check(d & 8'hFC, 8'h84);
    $display("standby test done");
  endtask
  task automatic end_of_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200us;
    errors++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_sw_tx();
    t_dma_tx();
    t_rx();
    t_standby();
    end_of_test();
  end
endmodule // tb_top

// >>> hw/spsf_fifo.v
`timescale 1ns/1ps
`include "spsf_defs.vh"

module spsf_fifo #(
  parameter WIDTH = `SPSF_FIFO_WIDTH,
  parameter DEPTH = `SPSF_FIFO_DEPTH,
  parameter AW = `SPSF_FIFO_AW
) (
  input wire clk,
  input wire rst_b,
  input wire in_valid,
  output reg in_ready,
  input wire [WIDTH-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;
  wire [AW:0] count_d;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign count_d = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_data = mem_q[rd_ptr_q];

  // ================================================================
  // storage; no reset on the array keeps it plain ram
  always @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // ================================================================
  // pointers and registered flags
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == DEPTH - 1) ? {AW{1'b0}} :
                    wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == DEPTH - 1) ? {AW{1'b0}} :
                    rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      count_q <= count_d;
      in_ready <= (count_d != DEPTH);
      out_valid <= (count_d != {(AW+1){1'b0}});
    end
  end

endmodule // spsf_fifo

// >>> hw/spsf_status.v
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "spsf_defs.vh"

module spsf_status #(
  parameter FIFO_DEPTH = `SPSF_FIFO_DEPTH,
  parameter FIFO_AW = `SPSF_FIFO_AW
) (
  input wire clk,
  input wire rst_b,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire standby,
  input wire tx_shift_ready,
  input wire tx_last_bit,
  output reg tx_load,
  output reg [7:0] tx_shift_data,
  output reg tx_multiproc_out,
  output reg transmitter_on,
  input wire rx_frame_done,
  input wire [7:0] rx_shift_data,
  input wire rx_parity_bit,
  input wire rx_stop_bit,
  input wire rx_multiproc_in,
  input wire dma_tx_valid,
  input wire [7:0] dma_tx_data,
  output wire dma_tx_ready,
  input wire dma_rx_rd,
  output reg [7:0] dma_rx_data,
  output reg [7:0] status_out
);

  // ================================================================
  // state
  reg [7:0] mode_q;
  reg [7:0] ctrl_q;
  reg tx_buffer_empty_q;
  reg rx_buffer_full_q;
  reg overrun_flag_q;
  reg framing_flag_q;
  reg parity_flag_q;
  reg tx_complete_q;
  reg rx_multiproc_bit_q;
  reg tx_multiproc_bit_q;
  reg [7:3] armed_q;

  reg tx_buffer_empty_d;
  reg rx_buffer_full_d;
  reg overrun_flag_d;
  reg framing_flag_d;
  reg parity_flag_d;
  reg tx_complete_d;
  reg [7:0] rdata_d;

  wire [7:0] stat_word;
  wire wr_stat;
  wire rd_stat;
  wire wr_ctrl;
  wire tx_disable;
  wire load_now;
  wire fifo_valid;
  wire [7:0] fifo_data;
  wire fifo_pop;
  wire rx_bad_parity;
  wire rx_good;
  wire sw_clr_txe;
  wire sw_clr_rxf;
  wire sw_clr_ovr;
  wire sw_clr_frm;
  wire sw_clr_par;
  wire rx_mp_d;
  wire tx_mp_d;

  // ================================================================
  // helpers
  function sw_clear;
    input armed;
    input flag;
    input wbit;
    begin
      // only a 0 written after the flag was seen as 1 clears it
      sw_clear = armed & flag & ~wbit;
    end
  endfunction

  function parity_ok;
    input [7:0] data;
    input pbit;
    input odd;
    begin
      // odd setting: data plus parity bit hold an odd count of ones
      parity_ok = ((^data) ^ pbit) == odd;
    end
  endfunction

  // ================================================================
  // decode
  assign stat_word = {tx_buffer_empty_q, rx_buffer_full_q,
                      overrun_flag_q, framing_flag_q, parity_flag_q,
                      tx_complete_q, rx_multiproc_bit_q,
                      tx_multiproc_bit_q};
  assign wr_stat = wr & (addr == `SPSF_OFS_STAT);
  assign rd_stat = rd & (addr == `SPSF_OFS_STAT);
  assign wr_ctrl = wr & (addr == `SPSF_OFS_CTRL);
  // only a falling enable counts; writing 0 over 0 is no event
  assign tx_disable = wr_ctrl & ctrl_q[`SPSF_B_TXON] & ~wdata[`SPSF_B_TXON];

  assign sw_clr_txe = wr_stat & sw_clear(armed_q[`SPSF_B_TXEMPTY],
    tx_buffer_empty_q, wdata[`SPSF_B_TXEMPTY]);
  assign sw_clr_rxf = wr_stat & sw_clear(armed_q[`SPSF_B_RXFULL],
    rx_buffer_full_q, wdata[`SPSF_B_RXFULL]);
  assign sw_clr_ovr = wr_stat & sw_clear(armed_q[`SPSF_B_OVERRUN],
    overrun_flag_q, wdata[`SPSF_B_OVERRUN]);
  assign sw_clr_frm = wr_stat & sw_clear(armed_q[`SPSF_B_FRAMING],
    framing_flag_q, wdata[`SPSF_B_FRAMING]);
  assign sw_clr_par = wr_stat & sw_clear(armed_q[`SPSF_B_PARITY],
    parity_flag_q, wdata[`SPSF_B_PARITY]);

  // holding register moves to the shift path only when it holds data
  assign load_now = transmitter_on & ~tx_buffer_empty_q & tx_shift_ready &
                    ~standby;
  // dma bytes wait in the fifo until the holding register frees up,
  // so a stalled transmitter pushes back on the dma controller
  assign fifo_pop = fifo_valid & tx_buffer_empty_q & ~standby;

  assign rx_bad_parity = mode_q[`SPSF_B_PEN] &
    ~parity_ok(rx_shift_data, rx_parity_bit, mode_q[`SPSF_B_ODD]);
  assign rx_good = rx_frame_done & ~rx_buffer_full_q & rx_stop_bit &
                   ~rx_bad_parity;

  // multiprocessor bits get next values too, so status_out never lags
  assign rx_mp_d = (rx_frame_done & ~standby) ? rx_multiproc_in :
                   rx_multiproc_bit_q;
  assign tx_mp_d = wr_stat ? wdata[`SPSF_B_TXMP] : tx_multiproc_bit_q;

  // ================================================================
  // transmit fifo on the dma path
  spsf_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_txfifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(dma_tx_valid),
    .in_ready(dma_tx_ready),
    .in_data(dma_tx_data),
    .out_valid(fifo_valid),
    .out_ready(tx_buffer_empty_q & ~standby),
    .out_data(fifo_data)
  );

  // ================================================================
  // flag next state; sets are applied after the clears so they win over them; standby is applied last and overrides both
  always @* begin
    tx_buffer_empty_d = tx_buffer_empty_q;
    tx_complete_d = tx_complete_q;
    rx_buffer_full_d = rx_buffer_full_q;
    overrun_flag_d = overrun_flag_q;
    framing_flag_d = framing_flag_q;
    parity_flag_d = parity_flag_q;

    if (sw_clr_txe || fifo_pop) begin
      tx_buffer_empty_d = 1'b0;
      tx_complete_d = 1'b0;
    end
    if (sw_clr_rxf || dma_rx_rd) begin
      rx_buffer_full_d = 1'b0;
    end
    if (sw_clr_ovr) begin
      overrun_flag_d = 1'b0;
    end
    if (sw_clr_frm) begin
      framing_flag_d = 1'b0;
    end
    if (sw_clr_par) begin
      parity_flag_d = 1'b0;
    end

    if (tx_disable || load_now) begin
      tx_buffer_empty_d = 1'b1;
    end
    if (tx_disable || (tx_last_bit && tx_buffer_empty_q)) begin
      tx_complete_d = 1'b1;
    end
    // a frame landing on a full buffer only flags overrun; data is lost
    if (rx_frame_done) begin
      if (rx_buffer_full_q) begin
        overrun_flag_d = 1'b1;
      end else begin
        if (!rx_stop_bit) begin
          framing_flag_d = 1'b1;
        end
        if (rx_bad_parity) begin
          parity_flag_d = 1'b1;
        end
        if (rx_good) begin
          rx_buffer_full_d = 1'b1;
        end
      end
    end

    // standby holds the flags at their reset pattern
    if (standby) begin
      tx_buffer_empty_d = 1'b1;
      tx_complete_d = 1'b1;
      rx_buffer_full_d = 1'b0;
      overrun_flag_d = 1'b0;
      framing_flag_d = 1'b0;
      parity_flag_d = 1'b0;
    end
  end

  // ================================================================
  // status flags
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // reset pattern: both transmit flags up, all else down
      tx_buffer_empty_q <= 1'b1;
      rx_buffer_full_q <= 1'b0;
      overrun_flag_q <= 1'b0;
      framing_flag_q <= 1'b0;
      parity_flag_q <= 1'b0;
      tx_complete_q <= 1'b1;
      rx_multiproc_bit_q <= 1'b0;
      tx_multiproc_bit_q <= 1'b0;
      armed_q <= 5'h00;
    end else begin
      tx_buffer_empty_q <= tx_buffer_empty_d;
      rx_buffer_full_q <= rx_buffer_full_d;
      overrun_flag_q <= overrun_flag_d;
      framing_flag_q <= framing_flag_d;
      parity_flag_q <= parity_flag_d;
      tx_complete_q <= tx_complete_d;
      rx_multiproc_bit_q <= rx_mp_d;
      tx_multiproc_bit_q <= tx_mp_d;
      // arming follows a read that saw 1; a flag at 0 disarms
      if (rd_stat) begin
        armed_q <= (armed_q | stat_word[7:3]) &
          {tx_buffer_empty_d, rx_buffer_full_d, overrun_flag_d,
           framing_flag_d, parity_flag_d};
      end else begin
        armed_q <= armed_q &
          {tx_buffer_empty_d, rx_buffer_full_d, overrun_flag_d,
           framing_flag_d, parity_flag_d};
      end
    end
  end

  // ================================================================
  // mode, control, receive holding register and transmit hand-off
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= `SPSF_RST_MODE;
      ctrl_q <= `SPSF_RST_CTRL;
      transmitter_on <= 1'b0;
      dma_rx_data <= `SPSF_RST_RXH;
      tx_load <= 1'b0;
      tx_multiproc_out <= 1'b0;
    end else begin
      if (wr && addr == `SPSF_OFS_MODE) begin
        mode_q <= wdata;
      end
      if (wr_ctrl) begin
        ctrl_q <= wdata;
        transmitter_on <= wdata[`SPSF_B_TXON];
      end
      // one-cycle load pulse; the shifter drops ready right after it
      tx_load <= load_now;
      if (load_now) begin
        tx_multiproc_out <= tx_multiproc_bit_q;
      end
      if (rx_good) begin
        dma_rx_data <= rx_shift_data;
      end
    end
  end

  // the holding register is copied into tx_shift_data, the byte handed to the shifter, on load_now;
  // the shifter takes it on the tx_load pulse
  reg [7:0] tx_hold_q;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_hold_q <= `SPSF_RST_TXH;
      tx_shift_data <= `SPSF_RST_TXH;
    end else begin
      // a dma byte and a software write in one cycle: dma wins
      if (fifo_pop) begin
        tx_hold_q <= fifo_data;
      end else if (wr && addr == `SPSF_OFS_TXH) begin
        tx_hold_q <= wdata;
      end
      if (load_now) begin
        tx_shift_data <= tx_hold_q;
      end
    end
  end

  // ================================================================
  // register read port, data one cycle after the strobe
  always @* begin
    rdata_d = 8'h00;
    case (addr)
      `SPSF_OFS_MODE: rdata_d = mode_q;
      `SPSF_OFS_CTRL: rdata_d = ctrl_q;
      `SPSF_OFS_TXH: rdata_d = tx_hold_q;
      `SPSF_OFS_STAT: rdata_d = stat_word;
      `SPSF_OFS_RXH: rdata_d = dma_rx_data;
      default: rdata_d = 8'h00;
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
      status_out <= `SPSF_RST_STAT;
    end else begin
      // idle bus reads back 00 so stale data never looks valid
      rdata <= rd ? rdata_d : 8'h00;
      status_out <= {tx_buffer_empty_d, rx_buffer_full_d,
                     overrun_flag_d, framing_flag_d, parity_flag_d,
                     tx_complete_d, rx_mp_d,
                     tx_mp_d};
    end
  end

endmodule // spsf_status
